// >>> jrxcfg_regs.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps

// Operation
// - Five-bit writable lane number, resets zero
// - Bit 7 set enables descrambling, else off
// - Eight-bit octets per frame, software keeps consistent
// - Eight-bit frames per multiframe, resets zero
// - Eight-bit converter count, resets zero
// - Two-bit control bits field at [7:6]
// - Subclass code 000 selects 0, 001 selects 1
module jrxcfg_regs
    import jrxcfg_pkg::*;
(
    // Clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rst_b_i,
    // Wishbone slave
    input  wire jrxcfg_wb_req_t  wb_req_i,
    output logic [31:0]          wb_dat_o,
    output logic                 wb_ack_o,
    // Settings to the link receiver
    output jrxcfg_cfg_t          link_cfg_o
);

    // ********************************************************
    // Address decode
    // ********************************************************

    // Word index of a byte address; low two bits ignored
    function automatic logic [11:0] reg_idx(input logic [15:0] adr);
        reg_idx = adr[13:2];
    endfunction

    // True when the address lands on the given register
    function automatic logic addr_is(input logic [15:0] adr, input logic [11:0] idx);
        addr_is = (adr[15:14] == 2'h0) && (reg_idx(adr) == idx);
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    logic        ack_r;      // Acknowledge, one cycle per request
    logic        ack_nxt;
    logic [31:0] rdat_r;     // Read data, valid with ack
    logic [31:0] rdat_nxt;
    jrxcfg_cfg_t cfg_r;      // Stored configuration
    jrxcfg_cfg_t cfg_nxt;
    logic        req_c;      // New request this cycle
    logic        wr_c;       // Write of byte lane 0 this cycle

    // ********************************************************
    // Bus handshake
    // ********************************************************

    // A request is taken once; ack blocks a second take of the same one
    always_comb
    begin
        req_c   = wb_req_i.cyc && wb_req_i.stb && !ack_r;
        wr_c    = req_c && wb_req_i.we && wb_req_i.sel[0];
        ack_nxt = req_c;
    end

    // ********************************************************
    // Configuration writes
    // ********************************************************

    // Only the documented field bits are stored, so reserved bits
    // can never leak into the link settings
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_c)
        begin
            // Field decode by register
            if (addr_is(wb_req_i.adr, IDX_LANE_ID))
            begin
                cfg_nxt.lane_number_cfg = wb_req_i.dat[LANE_MSB:0];
            end
            if (addr_is(wb_req_i.adr, IDX_DESCRAMBLER))
            begin
                // Descramble only when bit is one; is up to software
                cfg_nxt.descrambler_enable = wb_req_i.dat[DSCR_BIT];
            end
            if (addr_is(wb_req_i.adr, IDX_OCTETS))
            begin
                // No consistency check: the product is software's job
                cfg_nxt.octets_per_frame_cfg = wb_req_i.dat[7:0];
            end
            if (addr_is(wb_req_i.adr, IDX_FRAMES))
            begin
                cfg_nxt.frames_per_multiframe_cfg = wb_req_i.dat[7:0];
            end
            if (addr_is(wb_req_i.adr, IDX_CONVERTERS))
            begin
                cfg_nxt.converter_count_cfg = wb_req_i.dat[7:0];
            end
            if (addr_is(wb_req_i.adr, IDX_CTRL_BITS))
            begin
                cfg_nxt.control_bits_per_sample_cfg =
                    wb_req_i.dat[CSB_LSB+1:CSB_LSB];
            end
            if (addr_is(wb_req_i.adr, IDX_SUBCLASS))
            begin
                cfg_nxt.link_subclass_cfg =
                    wb_req_i.dat[SUBCLASS_LSB+2:SUBCLASS_LSB];
            end
        end
        // Mode decode; invalid codes fall back to subclass 0 behaviour
        cfg_nxt.subclass1_mode   = (cfg_nxt.link_subclass_cfg == SUBCLASS_1);
        cfg_nxt.subclass_invalid = (cfg_nxt.link_subclass_cfg != SUBCLASS_0) &&
                                   (cfg_nxt.link_subclass_cfg != SUBCLASS_1);
    end

    // ********************************************************
    // Read data
    // ********************************************************

    // Data is registered so it is steady while ack is high
    always_comb
    begin
        rdat_nxt = 32'h0000_0000;
        if (req_c && !wb_req_i.we)
        begin
            // Reserved and unmapped bits stay zero
            case (1'b1)
                addr_is(wb_req_i.adr, IDX_STATUS):
                    rdat_nxt[STAT_SUB1:STAT_INVALID] =
                        {cfg_r.subclass1_mode, cfg_r.subclass_invalid};
                addr_is(wb_req_i.adr, IDX_LANE_ID):
                    rdat_nxt[LANE_MSB:0] = cfg_r.lane_number_cfg;
                addr_is(wb_req_i.adr, IDX_DESCRAMBLER):
                    rdat_nxt[DSCR_BIT] = cfg_r.descrambler_enable;
                addr_is(wb_req_i.adr, IDX_OCTETS):
                    rdat_nxt[7:0] = cfg_r.octets_per_frame_cfg;
                addr_is(wb_req_i.adr, IDX_FRAMES):
                    rdat_nxt[7:0] = cfg_r.frames_per_multiframe_cfg;
                addr_is(wb_req_i.adr, IDX_CONVERTERS):
                    rdat_nxt[7:0] = cfg_r.converter_count_cfg;
                addr_is(wb_req_i.adr, IDX_CTRL_BITS):
                    rdat_nxt[CSB_LSB+1:CSB_LSB] = cfg_r.control_bits_per_sample_cfg;
                addr_is(wb_req_i.adr, IDX_SUBCLASS):
                    rdat_nxt[SUBCLASS_LSB+2:SUBCLASS_LSB] = cfg_r.link_subclass_cfg;
                // Unmapped address answers zero
                default:
                    rdat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************

    // Everything resets to zero, as the link expects
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
            cfg_r  <= CFG_RST;
        end
        else
        begin
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
            cfg_r  <= cfg_nxt;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = rdat_r;
    assign link_cfg_o = cfg_r;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking chk_cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Write of byte lane 0 to one register
    sequence wr_s(logic [11:0] idx);
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && wb_req_i.we &&
        wb_req_i.sel[0] && addr_is(wb_req_i.adr, idx);
    endsequence

    // Read request of one register
    sequence rd_s(logic [11:0] idx);
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && !wb_req_i.we &&
        addr_is(wb_req_i.adr, idx);
    endsequence

    // Answer one cycle after a new request
    ack_one_cycle_a: assert property (
        (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");

    lane_write_a: assert property (
        wr_s(IDX_LANE_ID) |=> link_cfg_o.lane_number_cfg == $past(wb_req_i.dat[4:0]))
        else $error("lane number not written");

    descrambler_write_a: assert property (
        wr_s(IDX_DESCRAMBLER) |=> link_cfg_o.descrambler_enable == $past(wb_req_i.dat[7]))
        else $error("descrambler enable not taken from bit 7");

    octets_write_a: assert property (
        wr_s(IDX_OCTETS) |=> link_cfg_o.octets_per_frame_cfg == $past(wb_req_i.dat[7:0]))
        else $error("octets per frame not written");

    frames_write_a: assert property (
        wr_s(IDX_FRAMES) |=>
            link_cfg_o.frames_per_multiframe_cfg == $past(wb_req_i.dat[7:0]))
        else $error("frames per multiframe not written");

    converters_write_a: assert property (
        wr_s(IDX_CONVERTERS) |=> link_cfg_o.converter_count_cfg == $past(wb_req_i.dat[7:0]))
        else $error("converter count not written");

    ctrl_bits_write_a: assert property (
        wr_s(IDX_CTRL_BITS) |=>
            link_cfg_o.control_bits_per_sample_cfg == $past(wb_req_i.dat[7:6]))
        else $error("control bits not taken from [7:6]");

    subclass_mode_a: assert property (
        wr_s(IDX_SUBCLASS) |=>
            (link_cfg_o.subclass1_mode == ($past(wb_req_i.dat[7:5]) == 3'h1)) &&
            (link_cfg_o.subclass_invalid == ($past(wb_req_i.dat[7:5]) > 3'h1)))
        else $error("subclass mode decode wrong");

    reserved_zero_a: assert property (
        (rd_s(IDX_SUBCLASS) |=> wb_dat_o[31:8] == 24'h0 && wb_dat_o[4:0] == 5'h0) and
        (rd_s(IDX_DESCRAMBLER) |=> wb_dat_o[6:0] == 7'h0) and
        (rd_s(IDX_CTRL_BITS) |=> wb_dat_o[5:0] == 6'h0))
        else $error("reserved bits read non-zero");

    config_hold_a: assert property (
        !(wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && wb_req_i.we) |=> $stable(link_cfg_o))
        else $error("config changed without a write");

    // ********************************************************
    // Read-back and bus checks
    // ********************************************************

    // Read data is zero whenever no answer is given
    data_idle_zero_a: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");

    // No answer without a fresh request one cycle before
    ack_needs_request_a: assert property (
        wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb && !wb_ack_o))
        else $error("ack without a request");

    // Byte lane 0 off: the write is refused
    sel_refused_a: assert property (
        (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && wb_req_i.we && !wb_req_i.sel[0])
            |=> $stable(link_cfg_o))
        else $error("config changed on a write without byte lane 0");

    // Lane number reads back in the low five bits
    lane_read_a: assert property (
        rd_s(IDX_LANE_ID) |=> wb_dat_o == {27'h0, $past(link_cfg_o.lane_number_cfg)})
        else $error("lane number read back wrong");

    // Descrambler enable reads back in bit 7 only
    descrambler_read_a: assert property (
        rd_s(IDX_DESCRAMBLER) |=>
            wb_dat_o == {24'h0, $past(link_cfg_o.descrambler_enable), 7'h0})
        else $error("descrambler enable read back wrong");

    // Whole-byte fields read back unchanged
    octets_read_a: assert property (
        rd_s(IDX_OCTETS) |=> wb_dat_o == {24'h0, $past(link_cfg_o.octets_per_frame_cfg)})
        else $error("octets per frame read back wrong");

    frames_read_a: assert property (
        rd_s(IDX_FRAMES) |=>
            wb_dat_o == {24'h0, $past(link_cfg_o.frames_per_multiframe_cfg)})
        else $error("frames per multiframe read back wrong");

    converters_read_a: assert property (
        rd_s(IDX_CONVERTERS) |=> wb_dat_o == {24'h0, $past(link_cfg_o.converter_count_cfg)})
        else $error("converter count read back wrong");

    // Control bits read back at the top of the byte
    ctrl_bits_read_a: assert property (
        rd_s(IDX_CTRL_BITS) |=>
            wb_dat_o == {24'h0, $past(link_cfg_o.control_bits_per_sample_cfg), 6'h0})
        else $error("control bits read back wrong");

    // Subclass code reads back as written, even an invalid one
    subclass_read_a: assert property (
        rd_s(IDX_SUBCLASS) |=>
            wb_dat_o == {24'h0, $past(link_cfg_o.link_subclass_cfg), 5'h0})
        else $error("subclass code read back wrong");

    // Status shows the decoded mode flags
    status_read_a: assert property (
        rd_s(IDX_STATUS) |=> wb_dat_o ==
            {30'h0, $past(link_cfg_o.subclass1_mode), $past(link_cfg_o.subclass_invalid)})
        else $error("status read back wrong");

    // Held in reset, every setting and the bus stay at zero
    reset_values_a: assert property (
        @(posedge mclk_i) disable iff (1'b0)
        !rst_b_i |-> (link_cfg_o == CFG_RST) && !wb_ack_o && (wb_dat_o == 32'h0000_0000))
        else $error("settings not zero during reset");

endmodule

// >>> jrxcfg_pkg.sv
package jrxcfg_pkg;

    // ********************************************************
    // Register map: word indices, byte address = index * 4
    // ********************************************************
    localparam logic [11:0] IDX_STATUS      = 12'h4a7; // Read-only link config status
    localparam logic [11:0] IDX_LANE_ID     = 12'h4a8; // Lane number in link
    localparam logic [11:0] IDX_DESCRAMBLER = 12'h4a9; // Descrambler control
    localparam logic [11:0] IDX_OCTETS      = 12'h4aa; // Octets per frame per lane
    localparam logic [11:0] IDX_FRAMES      = 12'h4ab; // Frames per multiframe/block
    localparam logic [11:0] IDX_CONVERTERS  = 12'h4ac; // Converters in link
    localparam logic [11:0] IDX_CTRL_BITS   = 12'h4ad; // Control bits per sample
    localparam logic [11:0] IDX_SUBCLASS    = 12'h4ae; // Link subclass select

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int unsigned LANE_MSB      = 4;  // Lane number [4:0]
    localparam int unsigned DSCR_BIT      = 7;  // Descrambler enable bit
    localparam int unsigned CSB_LSB       = 6;  // Control bits field [7:6]
    localparam int unsigned SUBCLASS_LSB  = 5;  // Subclass field [7:5]
    localparam int unsigned STAT_INVALID  = 0;  // Status: subclass code invalid
    localparam int unsigned STAT_SUB1     = 1;  // Status: subclass 1 active

    // ********************************************************
    // Codes and reset values
    // ********************************************************
    localparam logic [2:0]  SUBCLASS_0    = 3'h0; // Subclass 0 operation
    localparam logic [2:0]  SUBCLASS_1    = 3'h1; // Subclass 1 operation
    localparam logic [7:0]  BYTE_RST      = 8'h00; // Every config byte resets to zero

    // ********************************************************
    // Carriers
    // ********************************************************
    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [15:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } jrxcfg_wb_req_t;

    // Settings handed to the link receiver
    typedef struct packed {
        logic [4:0]  lane_number_cfg;
        logic        descrambler_enable;
        logic [7:0]  octets_per_frame_cfg;
        logic [7:0]  frames_per_multiframe_cfg;
        logic [7:0]  converter_count_cfg;
        logic [1:0]  control_bits_per_sample_cfg;
        logic [2:0]  link_subclass_cfg;
        logic        subclass1_mode;
        logic        subclass_invalid;
    } jrxcfg_cfg_t;

    localparam jrxcfg_cfg_t CFG_RST = '{
        lane_number_cfg:             BYTE_RST[4:0],
        descrambler_enable:          1'b0,
        octets_per_frame_cfg:        BYTE_RST,
        frames_per_multiframe_cfg:   BYTE_RST,
        converter_count_cfg:         BYTE_RST,
        control_bits_per_sample_cfg: BYTE_RST[1:0],
        link_subclass_cfg:           BYTE_RST[2:0],
        subclass1_mode:              1'b0,
        subclass_invalid:            1'b0
    };

endpackage

// >>> jrxcfg_link_sink.sv
`timescale 1ns/1ps

// ********************************************************
// Link receiver stand-in that consumes the settings
// ********************************************************
module jrxcfg_link_sink
    import jrxcfg_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // Settings from the register bank
    input  wire jrxcfg_cfg_t cfg_i,
    // Modes as the receiver applies them
    output logic             descramble_o,
    output logic             subclass1_o
);
    // Retimed once, so the receiver never acts on a settling value
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            descramble_o <= 1'b0;
            subclass1_o  <= 1'b0;
        end
        else
        begin
            descramble_o <= cfg_i.descrambler_enable;
            subclass1_o  <= (cfg_i.link_subclass_cfg == SUBCLASS_1);
        end
    end
endmodule

// >>> jesd_rx_link_param_config_tb_top.sv
`timescale 1ns/1ps

module jesd_rx_link_param_config_tb_top
    import jrxcfg_pkg::*;
;
    // ********************************************************
    // Signals and reference state
    // ********************************************************
    logic           mclk_i;    // Bench clock
    logic           rst_b_i;   // Reset, active low
    jrxcfg_wb_req_t req;       // Bus request
    logic [31:0]    rdat;      // Read data
    logic           ack;       // Bus ack
    jrxcfg_cfg_t    cfg;       // Settings out
    logic           dscr_seen; // Receiver descramble mode
    logic           sub1_seen; // Receiver subclass 1 mode
    int             n_errors;
    int             compares;
    int             seed;
    int             mdl [8];   // Reference bytes, status first
    logic [31:0]    q;         // Last read data
    logic [31:0]    d;         // Scratch write data
    // Writable bits; status is read-only, reserved bits stay zero
    localparam logic [7:0] MASK [8] = '{8'h00, 8'h1f, 8'h80, 8'hff, 8'hff, 8'hff, 8'hc0, 8'he0};

    jrxcfg_regs dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_req_i(req),
                     .wb_dat_o(rdat), .wb_ack_o(ack), .link_cfg_o(cfg));
    jrxcfg_link_sink sink (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cfg_i(cfg),
                           .descramble_o(dscr_seen), .subclass1_o(sub1_seen));

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    // Single comparison point
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    begin
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    end
    endtask

    // Settings expected from the reference bytes
    function automatic jrxcfg_cfg_t exp_cfg();
        jrxcfg_cfg_t e;
        e.lane_number_cfg             = mdl[1][4:0];
        e.descrambler_enable          = mdl[2][7];
        e.octets_per_frame_cfg        = mdl[3][7:0];
        e.frames_per_multiframe_cfg   = mdl[4][7:0];
        e.converter_count_cfg         = mdl[5][7:0];
        e.control_bits_per_sample_cfg = mdl[6][7:6];
        e.link_subclass_cfg           = mdl[7][7:5];
        e.subclass1_mode              = (mdl[7][7:5] == 3'h1);
        e.subclass_invalid            = (mdl[7][7:5] > 3'h1);
        return e;
    endfunction

    // One classic cycle; entered right after a rising edge; only the watchdog ends a wait
    task automatic wb(input logic we, input int k, input logic [3:0] sel, input logic [31:0] wd);
    begin
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {2'b00, 12'(IDX_STATUS + k), 2'b00},
                 sel: sel, dat: wd};
        @(posedge mclk_i);
        while (ack !== 1'b1)
            @(posedge mclk_i);
        q = rdat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge mclk_i);
    end
    endtask

    // Write, update reference, compare settings; index 8 is unmapped
    task automatic wr(input int k, input logic [3:0] sel, input logic [31:0] wd);
    begin
        wb(1'b1, k, sel, wd);
        if (k < 8 && sel[0])
            mdl[k] = int'(wd[7:0] & MASK[k]);
        chk(64'(cfg), 64'(exp_cfg()));
    end
    endtask

    // Read and compare against reference
    task automatic rd(input int k);
    begin
        wb(1'b0, k, 4'hf, $random(seed));
        if (k == 0)
            chk(64'(q), {62'h0, mdl[7][7:5] == 3'h1, mdl[7][7:5] > 3'h1});
        else
            chk(64'(q), (k < 8) ? 64'(mdl[k]) : 64'h0);
    end
    endtask

    // Verdict, reached from the sequence or the watchdog
    task automatic summarize();
    begin
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        mclk_i = 1'b0;
        rst_b_i = 1'b0;
        req = '0;
        n_errors = 0;
        compares = 0;
        seed = 32'h8304bcb7;
        mdl = '{default: 0};
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        // Every register, and one unmapped word, reads zero after reset
        for (int k = 0; k < 9; k++)
            rd(k);
        $display("test reset values done");
        // Random bytes, reserved and upper bits set too
        repeat (20)
        begin
            for (int k = 1; k < 7; k++)
            begin
                wr(k, 4'hf, $random(seed));
                rd(k);
            end
        end
        $display("test random fields done");
        // Mid-run reset clears every setting written above
        rst_b_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        mdl = '{default: 0};
        @(posedge mclk_i);
        for (int k = 0; k < 8; k++)
            rd(k);
        chk(64'(cfg), 64'(exp_cfg()));
        $display("test mid-run reset done");
        // Software keeps subclass to legal codes only
        for (int c = 0; c < 2; c++)
        begin
            d = $random(seed);
            wr(7, 4'h1, {d[31:8], 3'(c), d[4:0]});
            rd(7);
            rd(0);
            chk(64'(sub1_seen), 64'(c));
        end
        $display("test subclass done");
        // Descrambler on for a 64b/66b link, then off
        wr(2, 4'hf, 32'h0000_00ff);
        chk(64'(dscr_seen), 64'h1);
        wr(2, 4'hf, 32'hffff_ff7f);
        chk(64'(dscr_seen), 64'h0);
        $display("test descrambler done");
        // Refused writes: byte lane 0 off, read-only status, unmapped word
        wr(3, 4'he, $random(seed));
        wr(0, 4'hf, 32'h0000_00ff);
        wr(8, 4'hf, $random(seed));
        for (int k = 0; k < 9; k++)
            rd(k);
        $display("test refused writes done");
        summarize();
    end

    // Watchdog well beyond the thousand or fewer cycles needed
    initial
    begin
        #500000;
        n_errors++;
        summarize();
    end
endmodule
